// file: logic/bus_xcvr_pkg.sv
// Constants for the quad registered bus transceiver.
// Assumes a single 10 MHz core clock; all device pins are sampled.
package bus_xcvr_pkg;
   localparam int WORD_WIDTH = 4;
   localparam int SYNC_STAGES = 3;
   localparam logic [3:0] DRIVER_RESET = 4'h0;
   localparam logic [3:0] LATCH_RESET = 4'hF;
   localparam int CLK_PERIOD_NS = 100;
endpackage

// file: logic/pin_sync.sv
// Three-stage pin synchroniser with second/third stage agreement.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Raw and filtered levels
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stage1 <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // A bit changes only once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               level_out[i] <= INIT[i];
            end else if (stage2[i] == stage3[i]) begin
               level_out[i] <= stage3[i];
            end
         end
      end
   endgenerate
endmodule

// file: logic/quad_registered_bus_transceiver.sv
// Quad registered bus transceiver, modelled on the core clock.
// Assumes every pin is asynchronous; shared lines are resolved outside.
//
// Summary of operation
// - Select low routes word A into the register, high routes word B.
// - Driver register loads only on a rising driver register clock edge.
// - Steady driver clock keeps register contents unchanged.
// - Bus enable high floats drivers; low drives inverted register bits.
// - Receiver outputs present the inverse of each shared line.
// - Latch enable low keeps receiver latches transparent.
// - Latch enable high holds latch data until it returns low.
// - Output enable high floats receiver outputs; low presents latch data.
// - Receive with drivers off, latches open, outputs on; other drives.
`timescale 1ns/1ps
module quad_registered_bus_transceiver
   import bus_xcvr_pkg::*;
#(
   parameter int WIDTH = WORD_WIDTH
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Driver side
   input wire logic [WIDTH-1:0] word_a_in,
   input wire logic [WIDTH-1:0] word_b_in,
   input wire logic source_select,
   input wire logic driver_register_clock,
   input wire logic bus_drive_enable_n,
   // Shared lines
   input wire logic [WIDTH-1:0] shared_line_in,
   output logic [WIDTH-1:0] shared_line_out,
   output logic [WIDTH-1:0] shared_line_oe,
   // Receiver side
   input wire logic receiver_latch_enable_n,
   input wire logic receiver_output_enable_n,
   output logic [WIDTH-1:0] receiver_out,
   output logic [WIDTH-1:0] receiver_out_oe
);
   // ------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------
   // Reset values sized to the word
   localparam logic [WIDTH-1:0] DRIVER_INIT = WIDTH'(DRIVER_RESET);
   localparam logic [WIDTH-1:0] LATCH_INIT = WIDTH'(LATCH_RESET);

   // Synchronised data words and shared line levels
   logic [WIDTH-1:0] a_s;
   logic [WIDTH-1:0] b_s;
   logic [WIDTH-1:0] line_s;
   // Synchronised control levels
   logic [4:0] ctl_s;
   logic sel_s;
   logic clk_s;
   logic be_n_s;
   logic rle_n_s;
   logic oe_n_s;
   // Decoded shared controls
   logic drive_on;
   logic latch_open;
   logic rx_on;
   // Driver clock edge detection
   logic clk_prev;
   logic clk_rise;
   // Per-slice driver and receiver state
   logic [WIDTH-1:0] mux_word;
   logic [WIDTH-1:0] driver_reg;
   logic [WIDTH-1:0] latch_q;
   logic [WIDTH-1:0] next_latch;

   pin_sync #(.WIDTH(WIDTH), .INIT('0)) u_word_a_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pin_in(word_a_in),
      .level_out(a_s)
   );

   pin_sync #(.WIDTH(WIDTH), .INIT('0)) u_word_b_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pin_in(word_b_in),
      .level_out(b_s)
   );

   pin_sync #(.WIDTH(WIDTH), .INIT('0)) u_line_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pin_in(shared_line_in),
      .level_out(line_s)
   );

   pin_sync #(.WIDTH(5), .INIT(5'h1F)) u_ctl_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pin_in({source_select, driver_register_clock, bus_drive_enable_n,
               receiver_latch_enable_n, receiver_output_enable_n}),
      .level_out(ctl_s)
   );

   assign {sel_s, clk_s, be_n_s, rle_n_s, oe_n_s} = ctl_s;

   // ------------------------------------------------------------
   // Slice helpers
   // ------------------------------------------------------------
   // Two-input word multiplexer of one slice
   function automatic logic pick_source(
      input logic sel,
      input logic a_bit,
      input logic b_bit
   );
      return sel ? b_bit : a_bit;
   endfunction

   // Bus polarity, used on both the drive and the receive path
   function automatic logic invert_level(input logic level);
      return ~level;
   endfunction

   // Active-low control decode shared by all enables
   function automatic logic enable_active(input logic enable_n);
      return ~enable_n;
   endfunction

   // ------------------------------------------------------------
   // Control decode
   // ------------------------------------------------------------
   // one decode of each control serves every slice
   always_comb begin
      drive_on = enable_active(be_n_s);
      latch_open = enable_active(rle_n_s);
      rx_on = enable_active(oe_n_s);
   end

   // ------------------------------------------------------------
   // Driver clock edge detection
   // ------------------------------------------------------------
   // Reset high so a clock pin already high at release is no edge
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         clk_prev <= 1'b1;
      end else begin
         clk_prev <= clk_s;
      end
   end

   always_comb begin
      clk_rise = clk_s && !clk_prev;
   end

   // ------------------------------------------------------------
   // Bit slices
   // ------------------------------------------------------------
   // identical slices, shared controls
   genvar bit_i;
   generate
      for (bit_i = 0; bit_i < WIDTH; bit_i++) begin : g_slice
         always_comb begin
            mux_word[bit_i] = pick_source(sel_s, a_s[bit_i], b_s[bit_i]);
         end

         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               driver_reg[bit_i] <= DRIVER_INIT[bit_i];
            end else if (clk_rise) begin
               driver_reg[bit_i] <= mux_word[bit_i];
            end
         end

         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               shared_line_out[bit_i] <= invert_level(DRIVER_INIT[bit_i]);
            end else begin
               shared_line_out[bit_i] <= invert_level(driver_reg[bit_i]);
            end
         end

         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               shared_line_oe[bit_i] <= 1'b0;
            end else begin
               shared_line_oe[bit_i] <= drive_on;
            end
         end

         always_comb begin
            next_latch[bit_i] = latch_q[bit_i];
            if (latch_open) begin
               next_latch[bit_i] = invert_level(line_s[bit_i]);
            end
         end

         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               latch_q[bit_i] <= LATCH_INIT[bit_i];
            end else begin
               latch_q[bit_i] <= next_latch[bit_i];
            end
         end

         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               receiver_out[bit_i] <= LATCH_INIT[bit_i];
            end else begin
               receiver_out[bit_i] <= next_latch[bit_i];
            end
         end

         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               receiver_out_oe[bit_i] <= 1'b0;
            end else begin
               receiver_out_oe[bit_i] <= rx_on;
            end
         end
      end
   endgenerate
endmodule

// file: test/bus_xcvr_props.sv
// Checker for the transceiver ports.
// Assumes settled levels within eight core cycles of any pin change.
`timescale 1ns/1ps
module bus_xcvr_props #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Driver side
   input wire logic [WIDTH-1:0] word_a_in,
   input wire logic [WIDTH-1:0] word_b_in,
   input wire logic source_select,
   input wire logic driver_register_clock,
   input wire logic bus_drive_enable_n,
   // Shared lines
   input wire logic [WIDTH-1:0] shared_line_in,
   input wire logic [WIDTH-1:0] shared_line_out,
   input wire logic [WIDTH-1:0] shared_line_oe,
   // Receiver side
   input wire logic receiver_latch_enable_n,
   input wire logic receiver_output_enable_n,
   input wire logic [WIDTH-1:0] receiver_out,
   input wire logic [WIDTH-1:0] receiver_out_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_drive_enable: assert property (
      $stable(bus_drive_enable_n) [*8] |->
      shared_line_oe == {WIDTH{~bus_drive_enable_n}}) else $error("bus oe");
   a_rx_enable: assert property (
      $stable(receiver_output_enable_n) [*8] |->
      receiver_out_oe == {WIDTH{~receiver_output_enable_n}}) else $error("r oe");
   a_rx_follow: assert property (
      (!receiver_latch_enable_n && $stable(shared_line_in)) [*8] |->
      receiver_out == ~shared_line_in) else $error("receiver data");
   a_latch_hold: assert property (
      receiver_latch_enable_n [*8] |-> $stable(receiver_out))
      else $error("latch moved");
   a_reg_steady: assert property (
      $stable(driver_register_clock) [*8] |-> $stable(shared_line_out))
      else $error("register moved");
   a_reg_load: assert property (
      $stable({source_select, word_a_in, word_b_in}) [*5] ##0
      $rose(driver_register_clock) ##1 $stable({source_select, word_a_in,
      word_b_in, driver_register_clock}) [*7] |-> shared_line_out ==
      ~(source_select ? word_b_in : word_a_in)) else $error("register load");
   a_line_lanes: assert property (
      shared_line_oe == 0 || &shared_line_oe) else $error("bus oe lanes");
   a_rx_lanes: assert property (
      receiver_out_oe == 0 || &receiver_out_oe) else $error("r oe lanes");
endmodule
bind quad_registered_bus_transceiver bus_xcvr_props #(.WIDTH(WIDTH)) props (
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .word_a_in(word_a_in),
   .word_b_in(word_b_in),
   .source_select(source_select),
   .driver_register_clock(driver_register_clock),
   .bus_drive_enable_n(bus_drive_enable_n),
   .shared_line_in(shared_line_in),
   .shared_line_out(shared_line_out),
   .shared_line_oe(shared_line_oe),
   .receiver_latch_enable_n(receiver_latch_enable_n),
   .receiver_output_enable_n(receiver_output_enable_n),
   .receiver_out(receiver_out),
   .receiver_out_oe(receiver_out_oe)
);

// file: test/bus_peer.sv
// Other logic on the shared lines; resolves the wire level.
// Assumes the design's enables are low while it drives.
`timescale 1ns/1ps
module bus_peer (
   input wire logic core_clk,
   input wire logic drive_en,
   input wire logic [3:0] data,
   input wire logic [3:0] dut_out,
   input wire logic [3:0] dut_oe,
   output logic [3:0] line
);
   logic [3:0] idle = 4'h5;
   always @(posedge core_clk) idle <= ~idle;
   assign line = (dut_oe & dut_out) | (~dut_oe & (drive_en ? data : idle));
endmodule

// file: test/quad_registered_bus_transceiver_bench.sv
// Bench for the transceiver, inputs driven on the falling edge.
// Assumes the bus peer model resolves the shared lines.
`timescale 1ns/1ps
module quad_registered_bus_transceiver_bench;
   logic core_clk = 0, sys_rst = 1, s = 0, drc = 0, be_n = 1;
   logic rle_n = 0, oe_n = 1, pen = 0;
   logic [3:0] a = 0, b = 0, d = 0, lo, loe, ro, roe, ln, exp;
   logic [7:0] r = 8'h51;
   int num_errors = 0, checks_done = 0, cyc = 0;
   always #50 core_clk = ~core_clk;
   quad_registered_bus_transceiver dut (.core_clk, .sys_rst, .word_a_in(a),
      .word_b_in(b), .source_select(s), .driver_register_clock(drc),
      .bus_drive_enable_n(be_n), .shared_line_in(ln), .shared_line_out(lo),
      .shared_line_oe(loe), .receiver_latch_enable_n(rle_n),
      .receiver_output_enable_n(oe_n), .receiver_out(ro),
      .receiver_out_oe(roe));
   bus_peer peer (.core_clk, .drive_en(pen), .data(d), .dut_out(lo),
      .dut_oe(loe), .line(ln));
   function automatic logic [7:0] nx(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic logic [3:0] drv(input logic sel, input logic [3:0] x, y);
      return ~(sel ? y : x);
   endfunction
   task automatic check(input string n, input logic [3:0] seen, want);
      checks_done++;
      if (seen !== want) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, want, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task print_verdict;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge core_clk) if (++cyc == 4000) begin
      num_errors++;
      print_verdict;
   end
   initial begin
      step(10);
      sys_rst = 0;
      for (int i = 0; i < 12; i++) begin
         r = nx(r);
         {b, a} = r;
         s = i[0];
         be_n = i[1];
         pen = 0;
         step(6);
         drc = 1;
         step(8);
         check("line out", lo, drv(s, a, b));
         check("line oe", loe, {4{~be_n}});
         exp = lo;
         {s, a, b} = ~{s, a, b};
         step(6);
         drc = 0;
         step(8);
         check("held", lo, exp);
         be_n = 1;
         pen = 1;
         d = r[5:2];
         oe_n = 0;
         step(12);
         check("receive", ro, ~d);
         check("r oe", roe, 4'hF);
         rle_n = 1;
         step(6);
         d = ~d;
         step(8);
         check("latched", ro, d);
         oe_n = 1;
         rle_n = 0;
         step(8);
         check("r oe off", roe, 4'h0);
      end
      // Mid-run reset with the driver clock pin held high
      sys_rst = 1;
      drc = 1;
      step(10);
      check("rst line", lo, ~bus_xcvr_pkg::DRIVER_RESET);
      check("rst line oe", loe, 4'h0);
      check("rst r out", ro, bus_xcvr_pkg::LATCH_RESET);
      check("rst r oe", roe, 4'h0);
      // A clock pin already high at release is not a rising edge
      sys_rst = 0;
      s = 0;
      a = 4'hA;
      step(12);
      check("no edge", lo, ~bus_xcvr_pkg::DRIVER_RESET);
      drc = 0;
      step(6);
      drc = 1;
      step(8);
      check("first load", lo, drv(s, a, b));
      print_verdict;
   end
endmodule
